//--- core/pmc_map.svh
`ifndef PMC_MAP_SVH
`define PMC_MAP_SVH

// Clock rate of ref_clk in MHz
`define PMC_CLK_MHZ          20

// Mode codes shown on the mode output and used on the request port
`define PMC_MODE_RUN         2'h0
`define PMC_MODE_IDLE        2'h1
`define PMC_MODE_SLEEP       2'h2
`define PMC_MODE_DEEP        2'h3

// One-hot codes of the power mode state machine
`define PMC_ST_RUN           8'h01
`define PMC_ST_IDLE          8'h02
`define PMC_ST_SLP_SUSP      8'h04
`define PMC_ST_SLP_GATE      8'h08
`define PMC_ST_SLEEP         8'h10
`define PMC_ST_DSL_SUSP      8'h20
`define PMC_ST_DSL_GATE      8'h40
`define PMC_ST_DEEP          8'h80

// Settle time of each shutdown step, least time, rounded up to cycles
`define PMC_SETTLE_NS        500
`define PMC_SETTLE_CYC       ((`PMC_SETTLE_NS * `PMC_CLK_MHZ + 999) / 1000)

// Delay from watchdog prewarning interrupt to the actual reset
`define PMC_PREWARN_NS       2000
`define PMC_PREWARN_CYC      ((`PMC_PREWARN_NS * `PMC_CLK_MHZ + 999) / 1000)

// Number of peripheral units served
`define PMC_NUM_PERIPH       8

`endif

//--- core/pmc_pkg.sv
`include "pmc_map.svh"

package pmc_pkg;

    // Software-visible power mode
    typedef enum logic [1:0] {
        PMC_RUN   = `PMC_MODE_RUN,
        PMC_IDLE  = `PMC_MODE_IDLE,
        PMC_SLEEP = `PMC_MODE_SLEEP,
        PMC_DEEP  = `PMC_MODE_DEEP
    } pmc_mode_t;

    // Power mode state machine, one-hot
    typedef enum logic [7:0] {
        ST_RUN      = `PMC_ST_RUN,
        ST_IDLE     = `PMC_ST_IDLE,
        ST_SLP_SUSP = `PMC_ST_SLP_SUSP,
        ST_SLP_GATE = `PMC_ST_SLP_GATE,
        ST_SLEEP    = `PMC_ST_SLEEP,
        ST_DSL_SUSP = `PMC_ST_DSL_SUSP,
        ST_DSL_GATE = `PMC_ST_DSL_GATE,
        ST_DEEP     = `PMC_ST_DEEP
    } pmc_state_t;

endpackage

//--- core/pmc_wdt_if.sv
`timescale 1ns/1ns

// Link between the mode controller and the watchdog prewarning timer
interface pmc_wdt_if;
    logic freeze_n;   // Clock enable from the top
    logic start;      // Watchdog reset request, one-cycle pulse
    logic nmi;        // Prewarning interrupt, one-cycle pulse
    logic rst_out;    // Reset after the prewarning delay, held
    logic counting;   // Prewarning delay running

    modport ctrl  (output freeze_n, output start, input nmi, input rst_out, input counting);
    modport timer (input freeze_n, input start, output nmi, output rst_out, output counting);
endinterface

//--- core/pmc_sync.sv
`timescale 1ns/1ns

// Two-stage synchroniser for pin inputs, one chain per bit
module pmc_sync import pmc_pkg::*; #(
    parameter int          WIDTH = 2,
    parameter logic [31:0] INIT  = 32'h0000_0000
) (
    input  wire logic             ref_clk, // System clock
    input  wire logic             arst_n,  // Asynchronous reset, active low
    input  wire logic             clk_en,  // Freezes the chain while low
    input  wire logic [WIDTH-1:0] din,     // Asynchronous inputs
    output logic      [WIDTH-1:0] dout     // Synchronised outputs
);

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            logic meta_r;
            logic sync_r;
            // First stage feeds only the second stage
            always_ff @(posedge ref_clk or negedge arst_n) begin
                if (!arst_n) begin
                    meta_r <= INIT[gi];
                    sync_r <= INIT[gi];
                end else if (clk_en) begin
                    meta_r <= din[gi];
                    sync_r <= meta_r;
                end
            end
            assign dout[gi] = sync_r;
        end
    endgenerate

endmodule // pmc_sync

//--- core/pmc_prewarn.sv
`timescale 1ns/1ns
`include "pmc_map.svh"

// Watchdog reset prewarning: interrupt first, reset after a fixed delay
module pmc_prewarn import pmc_pkg::*; #(
    parameter int PREWARN_CYC = `PMC_PREWARN_CYC
) (
    input  wire logic ref_clk,    // System clock
    input  wire logic arst_n,     // Asynchronous reset, active low
    pmc_wdt_if.timer  wif         // Link to the mode controller
);

    localparam int CW = $clog2(PREWARN_CYC + 1);

    logic [CW-1:0] cnt_r;
    logic          counting_r;
    logic          nmi_r;
    logic          rst_r;
    wire           fire = counting_r && (cnt_r == CW'(PREWARN_CYC - 1));

    // Request starts the delay once; further requests are ignored
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r      <= '0;
            counting_r <= 1'b0;
            nmi_r      <= 1'b0;
            rst_r      <= 1'b0;
        end else if (wif.freeze_n) begin
            nmi_r <= wif.start && !counting_r && !rst_r;
            if (wif.start && !counting_r && !rst_r) begin
                counting_r <= 1'b1;
                cnt_r      <= '0;
            end else if (fire) begin
                counting_r <= 1'b0;
                rst_r      <= 1'b1;
            end else if (counting_r) begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end

    assign wif.nmi      = nmi_r;
    assign wif.rst_out  = rst_r;
    assign wif.counting = counting_r;

endmodule // pmc_prewarn

//--- core/pmc_top.sv
`timescale 1ns/1ns
`include "pmc_map.svh"

module pmc_top import pmc_pkg::*; #(
    parameter int NP          = `PMC_NUM_PERIPH,  // Peripheral units served
    parameter int SETTLE_CYC  = `PMC_SETTLE_CYC,  // Cycles per shutdown step
    parameter int PREWARN_CYC = `PMC_PREWARN_CYC  // Prewarning delay in cycles
) (
    input  wire logic          ref_clk,        // System oscillator clock
    input  wire logic          arst_n,         // Chip reset, asynchronous
    input  wire logic          clk_en,         // Freezes all state while low
    input  wire logic          mode_req_valid, // Software mode request strobe
    input  wire logic [1:0]    mode_req,       // Requested mode code
    input  wire logic [NP-1:0] periph_sw_en,   // Software clock enables
    input  wire logic [NP-1:0] periph_sleep_en,// Units that run in sleep
    input  wire logic [NP-1:0] periph_busy,    // Unit has work pending
    input  wire logic [NP-1:0] periph_irq,     // Unit interrupt requests
    input  wire logic [NP-1:0] irq_enable,     // Interrupt enables
    input  wire logic          wdt_event,      // Watchdog timer event pulse
    input  wire logic          wdt_reset_req,  // Watchdog reset request pulse
    input  wire logic          nmi_pin,        // NMI pin, asynchronous
    input  wire logic          ext_wake_pin,   // External wake pin, asynchronous
    output logic               cpu_clk_on,     // CPU clock gate enable
    output logic               sys_clk_on,     // System clock run enable
    output logic [NP-1:0]      periph_clk_on,  // Peripheral clock gate enables
    output logic [NP-1:0]      periph_suspend, // Suspend request per unit
    output logic [1:0]         mode,           // Current mode code
    output logic               seq_busy,       // Shutdown sequence in progress
    output logic               wake,           // Wake to run, one-cycle pulse
    output logic               nmi_trap,       // NMI trap request pulse
    output logic               wdt_reset       // Watchdog reset, held
);

    localparam int CW = $clog2(SETTLE_CYC + 1);

    // Pin inputs pass two flip-flops first; NMI idles high
    logic [1:0] pin_sync;
    logic       nmi_s;
    logic       ext_wake_s;
    logic       nmi_s_d_r;

    pmc_sync #(
        .WIDTH (2),
        .INIT  (32'h0000_0001)
    ) u_sync (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .clk_en  (clk_en),
        .din     ({ext_wake_pin, nmi_pin}),
        .dout    (pin_sync)
    );

    assign nmi_s      = pin_sync[0];
    assign ext_wake_s = pin_sync[1];

    // Watchdog prewarning timer
    pmc_wdt_if wif ();

    assign wif.freeze_n = clk_en;
    assign wif.start    = wdt_reset_req;

    pmc_prewarn #(
        .PREWARN_CYC (PREWARN_CYC)
    ) u_prewarn (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .wif     (wif)
    );

    // State and output registers
    pmc_state_t    state_r;
    pmc_state_t    state_nxt;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic          cpu_clk_on_r;
    logic          sys_clk_on_r;
    logic [NP-1:0] periph_clk_on_r;
    logic [NP-1:0] periph_clk_nxt;
    logic [NP-1:0] periph_suspend_r;
    logic [NP-1:0] periph_suspend_nxt;
    logic [1:0]    mode_r;
    logic [1:0]    mode_nxt;
    logic          seq_busy_r;
    logic          wake_r;
    logic          nmi_trap_r;
    logic          wdt_reset_r;

    // Wake sources
    wire           nmi_fall    = nmi_s_d_r && !nmi_s;
    wire           wdt_any     = wdt_event || wdt_reset_req || wif.nmi;
    wire [NP-1:0]  irq_act     = periph_irq & irq_enable;
    wire [NP-1:0]  irq_slp     = irq_act & periph_sleep_en & periph_sw_en;
    wire           wake_idle   = wdt_any || nmi_fall || (|irq_act);
    wire           wake_sleep  = wdt_any || nmi_fall || (|irq_slp);
    wire           wake_deep   = ext_wake_s;

    // Mode requests are taken only in run mode
    wire           req_ok      = mode_req_valid && (state_r == ST_RUN);
    wire           req_idle    = req_ok && (mode_req == `PMC_MODE_IDLE);
    wire           req_sleep   = req_ok && (mode_req == `PMC_MODE_SLEEP);
    wire           req_deep    = req_ok && (mode_req == `PMC_MODE_DEEP);

    // Step timer of the shutdown sequence
    wire           step_done   = (cnt_r == CW'(SETTLE_CYC - 1));

    // Automatic gating: a unit is clocked only while it has work
    wire [NP-1:0]  periph_need = periph_busy | periph_irq;
    wire [NP-1:0]  clk_run     = periph_sw_en & periph_need;
    wire [NP-1:0]  clk_sleep   = clk_run & periph_sleep_en;

    // Power mode state machine
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = '0;
        case (state_r)
            ST_RUN: begin
                if (req_idle) begin
                    state_nxt = ST_IDLE;
                end else if (req_sleep) begin
                    state_nxt = ST_SLP_SUSP;
                end else if (req_deep) begin
                    state_nxt = ST_DSL_SUSP;
                end
            end
            ST_IDLE: begin
                if (wake_idle) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_SLP_SUSP: begin
                if (wake_sleep) begin
                    state_nxt = ST_RUN;
                end else if (step_done) begin
                    state_nxt = ST_SLP_GATE;
                end else begin
                    cnt_nxt = cnt_r + 1'b1;
                end
            end
            ST_SLP_GATE: begin
                if (wake_sleep) begin
                    state_nxt = ST_RUN;
                end else if (step_done) begin
                    state_nxt = ST_SLEEP;
                end else begin
                    cnt_nxt = cnt_r + 1'b1;
                end
            end
            ST_SLEEP: begin
                if (wake_sleep) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_DSL_SUSP: begin
                if (wake_sleep || wake_deep) begin
                    state_nxt = ST_RUN;
                end else if (step_done) begin
                    state_nxt = ST_DSL_GATE;
                end else begin
                    cnt_nxt = cnt_r + 1'b1;
                end
            end
            ST_DSL_GATE: begin
                if (wake_sleep || wake_deep) begin
                    state_nxt = ST_RUN;
                end else if (step_done) begin
                    state_nxt = ST_DEEP;
                end else begin
                    cnt_nxt = cnt_r + 1'b1;
                end
            end
            ST_DEEP: begin
                if (wake_deep) begin
                    state_nxt = ST_RUN;
                end
            end
            default: begin
                state_nxt = ST_RUN;
            end
        endcase
    end

    // Clock, suspend and mode values for the next state
    always_comb begin
        periph_clk_nxt     = clk_run;
        periph_suspend_nxt = '0;
        mode_nxt           = `PMC_MODE_RUN;
        case (state_nxt)
            ST_RUN: begin
                periph_clk_nxt = clk_run;
            end
            ST_IDLE: begin
                periph_clk_nxt = clk_run;
                mode_nxt       = `PMC_MODE_IDLE;
            end
            ST_SLP_SUSP: begin
                periph_suspend_nxt = ~periph_sleep_en;
                mode_nxt           = `PMC_MODE_SLEEP;
            end
            ST_SLP_GATE, ST_SLEEP: begin
                periph_clk_nxt     = clk_sleep;
                periph_suspend_nxt = ~periph_sleep_en;
                mode_nxt           = `PMC_MODE_SLEEP;
            end
            ST_DSL_SUSP: begin
                periph_suspend_nxt = '1;
                mode_nxt           = `PMC_MODE_DEEP;
            end
            ST_DSL_GATE, ST_DEEP: begin
                periph_clk_nxt     = '0;
                periph_suspend_nxt = '1;
                mode_nxt           = `PMC_MODE_DEEP;
            end
            default: begin
                periph_clk_nxt = clk_run;
            end
        endcase
    end

    // State register
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= ST_RUN;
            cnt_r   <= '0;
        end else if (clk_en) begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    // Clock gate and suspend registers
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cpu_clk_on_r     <= 1'b1;
            sys_clk_on_r     <= 1'b1;
            periph_clk_on_r  <= '0;
            periph_suspend_r <= '0;
        end else if (clk_en) begin
            cpu_clk_on_r     <= (state_nxt == ST_RUN);
            sys_clk_on_r     <= (state_nxt != ST_DEEP);
            periph_clk_on_r  <= periph_clk_nxt;
            periph_suspend_r <= periph_suspend_nxt;
        end
    end

    // Mode, status and event registers
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_r      <= `PMC_MODE_RUN;
            seq_busy_r  <= 1'b0;
            wake_r      <= 1'b0;
            nmi_s_d_r   <= 1'b1;
            nmi_trap_r  <= 1'b0;
            wdt_reset_r <= 1'b0;
        end else if (clk_en) begin
            mode_r      <= mode_nxt;
            seq_busy_r  <= state_nxt[2] || state_nxt[3] || state_nxt[5] || state_nxt[6];
            wake_r      <= (state_r != ST_RUN) && (state_nxt == ST_RUN);
            nmi_s_d_r   <= nmi_s;
            nmi_trap_r  <= nmi_fall || wif.nmi;
            wdt_reset_r <= wif.rst_out;
        end
    end

    assign cpu_clk_on     = cpu_clk_on_r;
    assign sys_clk_on     = sys_clk_on_r;
    assign periph_clk_on  = periph_clk_on_r;
    assign periph_suspend = periph_suspend_r;
    assign mode           = mode_r;
    assign seq_busy       = seq_busy_r;
    assign wake           = wake_r;
    assign nmi_trap       = nmi_trap_r;
    assign wdt_reset      = wdt_reset_r;

endmodule // pmc_top

//--- tb/pmc_periph_model.sv
`timescale 1ns/1ns

// Peripheral units: work on demand, interrupts only from units that run
module pmc_periph_model #(
    parameter int NP = 8  // Units served
) (
    input  wire logic          ref_clk,        // System clock
    input  wire logic          arst_n,         // Reset, active low
    input  wire logic [NP-1:0] periph_clk_on,  // Clock gates from the block
    input  wire logic [NP-1:0] periph_suspend, // Suspend from the block
    input  wire logic [NP-1:0] work,           // Work handed out by the bench
    output logic      [NP-1:0] periph_busy,    // Unit has work
    output logic      [NP-1:0] periph_irq      // Interrupt after running
);
    // An unclocked or suspended unit never finishes, so it stays silent
    assign periph_busy = work;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            periph_irq <= '0;
        end else begin
            periph_irq <= work & periph_clk_on & ~periph_suspend;
        end
    end
endmodule // pmc_periph_model

//--- tb/pmc_top_chk.sv
`timescale 1ns/1ns

// Port checker of the power mode controller
module pmc_top_chk #(
    parameter int NP          = 8, // Units served
    parameter int PREWARN_CYC = 4  // Prewarning delay
) (
    input wire logic          ref_clk,         // Clock
    input wire logic          arst_n,          // Reset
    input wire logic          clk_en,          // Freeze
    input wire logic          mode_req_valid,  // Request strobe
    input wire logic [1:0]    mode_req,        // Request code
    input wire logic [NP-1:0] periph_sw_en,    // Clock enables
    input wire logic [NP-1:0] periph_sleep_en, // Run in sleep
    input wire logic [NP-1:0] periph_busy,     // Work pending
    input wire logic [NP-1:0] periph_irq,      // Interrupts
    input wire logic [NP-1:0] irq_enable,      // Enables
    input wire logic          wdt_event,       // Watchdog event
    input wire logic          wdt_reset_req,   // Watchdog reset request
    input wire logic          nmi_pin,         // NMI pin
    input wire logic          ext_wake_pin,    // Wake pin
    input wire logic          cpu_clk_on,      // CPU clock
    input wire logic          sys_clk_on,      // System clock
    input wire logic [NP-1:0] periph_clk_on,   // Unit clocks
    input wire logic [NP-1:0] periph_suspend,  // Unit suspend
    input wire logic [1:0]    mode,            // Mode
    input wire logic          seq_busy,        // Shutdown running
    input wire logic          wake,            // Wake pulse
    input wire logic          nmi_trap,        // NMI trap
    input wire logic          wdt_reset        // Watchdog reset
);
    logic [7:0] since_nmi_r;   // Cycles since the last trap pulse
    logic [7:0] since_nmi_nxt;

    // Saturating count, restarted by every trap pulse
    assign since_nmi_nxt = nmi_trap ? 8'h00 : (since_nmi_r == 8'hFF) ? 8'hFF : since_nmi_r + 8'h01;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            since_nmi_r <= 8'hFF;
        end else begin
            since_nmi_r <= since_nmi_nxt;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    // Request taken in run, idle with the watchdog, deep sleep with the wake pin low
    sequence s_req(logic [1:0] code);
        mode == 2'h0 && clk_en && mode_req_valid && mode_req == code;
    endsequence
    sequence s_idle_wdt;
        mode == 2'h1 && clk_en && wdt_event;
    endsequence
    sequence s_deep_quiet;
        (mode == 2'h3 && !sys_clk_on && !ext_wake_pin)[*4];
    endsequence

    AST_RUN_CPU_CLK: assert property ((mode == 2'h0) == cpu_clk_on)
        else $error("cpu clock not tied to run mode");
    AST_DEEP_SYS: assert property (!sys_clk_on |-> mode == 2'h3 && !cpu_clk_on)
        else $error("system clock stopped outside deep sleep");
    AST_REQ_IDLE: assert property (s_req(2'h1) |=> mode == 2'h1 && !cpu_clk_on && !seq_busy)
        else $error("idle request not honoured");
    AST_REQ_SLEEP: assert property (s_req(2'h2) |=> seq_busy && mode == 2'h2 && periph_suspend == ~$past(periph_sleep_en))
        else $error("sleep entry not stepped");
    AST_IDLE_WAKE: assert property (s_idle_wdt |=> wake && mode == 2'h0)
        else $error("watchdog did not wake idle");
    AST_DEEP_HOLD: assert property (s_deep_quiet |=> mode == 2'h3)
        else $error("deep sleep left without wake pin");
    AST_SLEEP_GATE: assert property (mode == 2'h2 && !seq_busy |-> (periph_clk_on & ~periph_sleep_en) == '0)
        else $error("non-sleep unit clocked in sleep");
    AST_AUTO_GATE: assert property ($past(arst_n) && mode == 2'h0 && $past(mode) == 2'h0
        |-> periph_clk_on == $past(periph_sw_en & (periph_busy | periph_irq)))
        else $error("unit clock not following demand");
    AST_PREWARN_DELAY: assert property ($rose(wdt_reset) |-> since_nmi_r >= PREWARN_CYC - 3 && since_nmi_r <= PREWARN_CYC)
        else $error("watchdog reset not delayed after trap");
    AST_RESET_HELD: assert property (wdt_reset |=> wdt_reset)
        else $error("watchdog reset dropped");
    AST_WAKE_PULSE: assert property (wake |-> mode == 2'h0 && cpu_clk_on ##1 !wake)
        else $error("wake pulse malformed");
endmodule // pmc_top_chk

bind pmc_top pmc_top_chk #(.NP(NP), .PREWARN_CYC(PREWARN_CYC)) u_chk (
    .ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en), .mode_req_valid(mode_req_valid),
    .mode_req(mode_req), .periph_sw_en(periph_sw_en), .periph_sleep_en(periph_sleep_en),
    .periph_busy(periph_busy), .periph_irq(periph_irq), .irq_enable(irq_enable),
    .wdt_event(wdt_event), .wdt_reset_req(wdt_reset_req), .nmi_pin(nmi_pin),
    .ext_wake_pin(ext_wake_pin), .cpu_clk_on(cpu_clk_on), .sys_clk_on(sys_clk_on),
    .periph_clk_on(periph_clk_on), .periph_suspend(periph_suspend), .mode(mode),
    .seq_busy(seq_busy), .wake(wake), .nmi_trap(nmi_trap), .wdt_reset(wdt_reset));

//--- tb/pmc_top_tb.sv
`timescale 1ns/1ns

module pmc_top_tb;
    localparam int S = 2;  // Shutdown step length
    localparam int P = 4;  // Prewarning delay
    logic ref_clk = 1'b0, arst_n = 1'b0, clk_en = 1'b1, mode_req_valid = 1'b0;
    logic wdt_event = 1'b0, wdt_reset_req = 1'b0, nmi_pin = 1'b1, ext_wake_pin = 1'b0;
    logic [1:0] mode_req = 2'h0;
    logic [7:0] sw_en = 8'h00, slp_en = 8'h00, work = 8'h00, irq_en = 8'h00;
    logic [7:0] busy, irq, periph_clk_on, periph_suspend;
    logic [1:0] mode;
    logic cpu_clk_on, sys_clk_on, seq_busy, wake, nmi_trap, wdt_reset, seen;
    int n_mismatch = 0, cmp_count = 0, cycles = 0, n;
    logic [31:0] seed;

    pmc_top #(.NP(8), .SETTLE_CYC(S), .PREWARN_CYC(P)) DUT (
        .ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en), .mode_req_valid(mode_req_valid),
        .mode_req(mode_req), .periph_sw_en(sw_en), .periph_sleep_en(slp_en),
        .periph_busy(busy), .periph_irq(irq), .irq_enable(irq_en), .wdt_event(wdt_event),
        .wdt_reset_req(wdt_reset_req), .nmi_pin(nmi_pin), .ext_wake_pin(ext_wake_pin),
        .cpu_clk_on(cpu_clk_on), .sys_clk_on(sys_clk_on), .periph_clk_on(periph_clk_on),
        .periph_suspend(periph_suspend), .mode(mode), .seq_busy(seq_busy), .wake(wake),
        .nmi_trap(nmi_trap), .wdt_reset(wdt_reset));
    pmc_periph_model #(.NP(8)) u_periph (
        .ref_clk(ref_clk), .arst_n(arst_n), .periph_clk_on(periph_clk_on),
        .periph_suspend(periph_suspend), .work(work), .periph_busy(busy), .periph_irq(irq));

    // Clock and hang guard
    always #25 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            $display("BAD run length expected end seen hang");
            give_verdict();
        end
    end

    // Expected unit clocks under demand gating
    function automatic logic [7:0] exp_gate(input logic [7:0] en, input logic [7:0] need);
        return en & need;
    endfunction

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_b(input string what, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk);
        #2;
    endtask
    // One-cycle software request
    task automatic req(input logic [1:0] code);
        mode_req = code;
        mode_req_valid = 1'b1;
        tick(1);
        mode_req_valid = 1'b0;
    endtask
    task automatic wait_wake();
        n = 0;
        while (wake !== 1'b1 && n < 8) begin
            tick(1);
            n++;
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        seed = 32'hBD92;
        tick(3);
        chk_b("rst cpu clk", 1'b1, cpu_clk_on);
        chk("rst mode", 8'h00, {6'h00, mode});
        chk("rst suspend", 8'h00, periph_suspend);
        arst_n = 1'b1;
        // Demand gating with random enables and work; code 0 does nothing
        for (int i = 0; i < 16; i++) begin
            sw_en = 8'($random(seed));
            work = 8'($random(seed));
            tick(2);
            chk("auto gate", exp_gate(sw_en, work), periph_clk_on);
        end
        req(2'h0);
        chk("code 0", 8'h00, {6'h00, mode});
        $display("test gating done");
        // Idle and sleep against a unit interrupt, the watchdog event and the NMI pin
        sw_en = 8'hFF;
        for (int m = 1; m <= 2; m++) begin
            for (int k = 0; k < 3; k++) begin
                work = 8'h00;
                irq_en = 8'hFF;
                slp_en = 8'($random(seed)) | 8'h01;
                tick(2);
                req(m[1:0]);
                chk("mode", m[7:0], {6'h00, mode});
                chk_b("cpu clk", 1'b0, cpu_clk_on);
                if (m == 2) begin
                    chk("suspend", ~slp_en, periph_suspend);
                    chk_b("step", 1'b1, seq_busy);
                    tick(2 * S + 1);
                    chk_b("step end", 1'b0, seq_busy);
                    work = ~slp_en;
                    tick(6);
                    chk("stopped unit", 8'h02, {6'h00, mode});
                end
                // Let an edge pass so the strobe is not raised as it drops
                tick(1);
                req(2'h3);
                chk("refused", m[7:0], {6'h00, mode});
                if (k == 0) work = work | 8'h01;
                if (k == 1) wdt_event = 1'b1;
                if (k == 2) nmi_pin = 1'b0;
                tick(1);
                wdt_event = 1'b0;
                wait_wake();
                chk_b("wake", 1'b1, wake);
                chk("woken mode", 8'h00, {6'h00, mode});
                nmi_pin = 1'b1;
                work = 8'h00;
                irq_en = 8'h00;
                $display("test mode %0d source %0d done", m, k);
            end
        end
        // Deep sleep ignores internal events and the NMI pin
        tick(4);
        req(2'h3);
        tick(2 * S + 3);
        chk_b("sys clk", 1'b0, sys_clk_on);
        chk("deep suspend", 8'hFF, periph_suspend);
        chk("deep clocks", 8'h00, periph_clk_on);
        irq_en = 8'hFF;
        work = 8'hFF;
        wdt_event = 1'b1;
        nmi_pin = 1'b0;
        tick(1);
        wdt_event = 1'b0;
        tick(8);
        chk("deep hold", 8'h03, {6'h00, mode});
        ext_wake_pin = 1'b1;
        wait_wake();
        chk_b("deep wake", 1'b1, wake);
        ext_wake_pin = 1'b0;
        nmi_pin = 1'b1;
        work = 8'h00;
        irq_en = 8'h00;
        $display("test deep done");
        // Prewarning: trap first, reset after the delay, repeats ignored
        tick(4);
        wdt_reset_req = 1'b1;
        tick(1);
        wdt_reset_req = 1'b0;
        n = 0;
        while (nmi_trap !== 1'b1 && n < 10) begin
            tick(1);
            n++;
        end
        chk("trap delay", 8'h01, n[7:0]);
        chk_b("early reset", 1'b0, wdt_reset);
        while (wdt_reset !== 1'b1 && n < 40) begin
            tick(1);
            n++;
        end
        chk_b("reset delay", 1'b1, n >= P + 1 && n <= P + 2);
        wdt_reset_req = 1'b1;
        tick(1);
        wdt_reset_req = 1'b0;
        seen = 1'b0;
        repeat (6) begin
            tick(1);
            seen = seen | nmi_trap;
        end
        chk_b("repeat trap", 1'b0, seen);
        arst_n = 1'b0;
        tick(2);
        chk_b("reset clears", 1'b0, wdt_reset);
        arst_n = 1'b1;
        tick(3);
        $display("test prewarning done");
        // A frozen block takes no request
        clk_en = 1'b0;
        req(2'h1);
        chk("frozen", 8'h00, {6'h00, mode});
        clk_en = 1'b1;
        tick(2);
        chk("unfrozen", 8'h00, {6'h00, mode});
        $display("test freeze done");
        give_verdict();
    end
endmodule // pmc_top_tb
